// ### hw/serial_cfg_pkg.sv
// shared constants and carrier types for the serial port configuration block
package serial_cfg_pkg;
   // register address space seen by the serial port framer
   localparam int ADDR_W = 12;
   localparam int DATA_W = 8;
   // printed register offsets
   localparam logic [ADDR_W-1:0] CFG_OFS = 12'h000;
   localparam logic [ADDR_W-1:0] RBSEL_OFS = 12'h004;
   // first address of the double-buffered control register window
   localparam logic [ADDR_W-1:0] BANK_BASE = 12'h010;
   // field positions in the port configuration register
   localparam int DIR_BIT = 7;
   localparam int ORDER_BIT = 6;
   localparam int SRST_BIT = 5;
   // field position in the readback select register
   localparam int RBSEL_BIT = 0;
   // reset values
   localparam logic [DATA_W-1:0] CFG_RST = 8'h00;
   localparam logic RBSEL_RST = 1'b0;
   localparam logic [DATA_W-1:0] BANK_RST = 8'h00;
   localparam logic [DATA_W-1:0] UNMAPPED_VAL = 8'h00;
   // one register access from the serial framer, on the link clock
   typedef struct packed {
      logic wr;
      logic rd;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
   } reg_req_t;
   // answer to the framer
   typedef struct packed {
      logic valid;
      logic [DATA_W-1:0] rdata;
      logic [ADDR_W-1:0] next_addr;
   } reg_rsp_t;
   // effective port mode after the i2c override
   typedef struct packed {
      logic out_pin_dir;
      logic lsb_first;
      logic step_up;
      logic rb_active;
   } port_mode_t;
   // core side update handshake states, gray along the path
   typedef enum logic [1:0] {
      UPD_IDLE = 2'b00,
      UPD_BUSY = 2'b01
   } update_state_t;
endpackage

// ### hw/bit_sync.sv
// two flip-flop synchroniser for independent level signals
`timescale 1ns/1ps
`default_nettype none
module bit_sync #(
   parameter int W = 1,
   parameter logic RST_VAL = 1'b0
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic [W-1:0] d_i,
   output logic [W-1:0] q_o
);
   // first stage, read only by the second stage
   logic [W-1:0] meta;
   // both stages reset to a constant
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
      begin
         meta <= {W{RST_VAL}};
         q_o <= {W{RST_VAL}};
      end
      else
      begin
         meta <= d_i;
         q_o <= meta;
      end
   end
endmodule
`default_nettype wire

// ### hw/byte_bank.sv
// small bank of byte registers with clear, bulk load and registered read
`timescale 1ns/1ps
`default_nettype none
module byte_bank #(
   parameter int DEPTH = 16,
   parameter int AW = 4,
   parameter logic [7:0] RST_VAL = 8'h00
) (
   input wire logic clk_i,
   input wire logic rst_b_i,
   input wire logic clear_i,
   input wire logic wr_i,
   input wire logic [AW-1:0] wr_addr_i,
   input wire logic [7:0] wr_data_i,
   input wire logic load_i,
   input wire logic [DEPTH*8-1:0] load_data_i,
   input wire logic [AW-1:0] rd_addr_i,
   output logic [7:0] rd_data_o,
   output logic [DEPTH*8-1:0] all_o
);
   // storage, flops so a clear reaches every entry at once
   logic [7:0] mem [DEPTH];
   if (DEPTH < 1 || DEPTH > (1 << AW))
   begin : g_bad_depth
      $error("byte_bank depth does not fit its address width");
   end
   // one entry per loop step; clear beats load beats write
   for (genvar i = 0; i < DEPTH; i++)
   begin : g_entry
      always_ff @(posedge clk_i or negedge rst_b_i)
      begin
         if (!rst_b_i)
            mem[i] <= RST_VAL;
         else if (clear_i)
            mem[i] <= RST_VAL;
         else if (load_i)
            mem[i] <= load_data_i[i*8 +: 8];
         else if (wr_i && wr_addr_i == AW'(i))
            mem[i] <= wr_data_i;
      end
      assign all_o[i*8 +: 8] = mem[i];
   end
   // registered read; out of range reads give the reset value
   always_ff @(posedge clk_i or negedge rst_b_i)
   begin
      if (!rst_b_i)
         rd_data_o <= RST_VAL;
      else if (32'(rd_addr_i) < DEPTH)
         rd_data_o <= mem[rd_addr_i];
      else
         rd_data_o <= RST_VAL;
   end
endmodule
`default_nettype wire

// ### hw/serial_port_config_regs.sv
// serial port configuration registers with buffered and active control banks
`timescale 1ns/1ps
`default_nettype none
module serial_port_config_regs #(
   parameter int BANK_DEPTH = 16,
   parameter int BANK_AW = 4
) (
   input wire logic core_clk_i,
   input wire logic rst_b_i,
   input wire logic link_clk_i,
   input wire logic i2c_mode_i,
   input wire serial_cfg_pkg::reg_req_t reg_req_i,
   output serial_cfg_pkg::reg_rsp_t reg_rsp_o,
   input wire logic read_drive_i,
   output logic data_pin_o,
   output logic data_pin_oe_o,
   output logic serial_output_pin_o,
   output logic serial_output_pin_oe_o,
   output serial_cfg_pkg::port_mode_t port_mode_o,
   output logic [BANK_DEPTH*8-1:0] active_regs_o,
   input wire logic update_i,
   output logic update_busy_o,
   output logic soft_reset_seen_o,
   output serial_cfg_pkg::port_mode_t core_mode_o
);
   import serial_cfg_pkg::*;

   if (BANK_DEPTH < 1 || BANK_DEPTH > (1 << BANK_AW) ||
       32'(BANK_BASE) + BANK_DEPTH > (1 << ADDR_W))
   begin : g_bad_bank
      $error("control bank does not fit the address space");
   end

   // reverse a byte when the port runs lsb first
   function automatic logic [7:0] order_byte(input logic [7:0] b, input logic rev);
      logic [7:0] r;
      r = b;
      if (rev)
      begin
         for (int k = 0; k < 8; k++)
            r[k] = b[7-k];
      end
      return r;
   endfunction

   logic core_rst_b; // released reset, core domain
   logic link_rst_b; // released reset, link domain
   logic i2c_q; // synchronised protocol strap

   // core reset release through two flops
   bit_sync #(.W(1), .RST_VAL(1'b0)) u_core_rst (.clk_i(core_clk_i), .rst_b_i(rst_b_i),
      .d_i(1'b1), .q_o(core_rst_b));
   // link reset release; the link clock may stand still, so release waits for it
   bit_sync #(.W(1), .RST_VAL(1'b0)) u_link_rst (.clk_i(link_clk_i), .rst_b_i(rst_b_i),
      .d_i(1'b1), .q_o(link_rst_b));
   // protocol select pin comes from outside, so it is synchronised
   bit_sync #(.W(1), .RST_VAL(1'b0)) u_i2c_sync (.clk_i(link_clk_i), .rst_b_i(link_rst_b),
      .d_i(i2c_mode_i), .q_o(i2c_q));

   logic [7:0] cfg; // port configuration byte as written
   logic rb_active; // readback select
   logic soft_go; // soft reset executes on this edge
   logic dir_eff; // effective output pin direction
   logic lsb_eff; // effective bit order and address step
   logic [7:0] wdata_ord; // write byte in register bit order
   logic [ADDR_W-1:0] bank_ofs; // request address relative to the bank
   logic in_bank; // request falls into the control bank
   logic hit_cfg; // request addresses the configuration register
   logic hit_rbsel; // request addresses the readback select register

   // the soft reset bit is live for exactly one edge after its write
   assign soft_go = cfg[SRST_BIT];
   // i2c mode has no order or direction choice
   assign dir_eff = cfg[DIR_BIT] & ~i2c_q;
   assign lsb_eff = cfg[ORDER_BIT] & ~i2c_q;
   // serial bytes arrive first bit in bit 7; lsb first reverses them
   assign wdata_ord = order_byte(reg_req_i.wdata, lsb_eff);
   // address decode
   assign bank_ofs = reg_req_i.addr - BANK_BASE;
   assign in_bank = (reg_req_i.addr >= BANK_BASE) &&
                    (bank_ofs < ADDR_W'(BANK_DEPTH));
   assign hit_cfg = (reg_req_i.addr == CFG_OFS);
   assign hit_rbsel = (reg_req_i.addr == RBSEL_OFS);

   // configuration register; a write beats the self-clear so a new soft reset is never lost
   always_ff @(posedge link_clk_i or negedge link_rst_b)
   begin
      if (!link_rst_b)
         cfg <= CFG_RST;
      else if (reg_req_i.wr && hit_cfg)
         cfg <= wdata_ord; // low nibble stored as sent, only high bits act
      else if (soft_go)
         cfg <= CFG_RST; // clears itself one link clock after the write
   end

   // readback select register
   always_ff @(posedge link_clk_i or negedge link_rst_b)
   begin
      if (!link_rst_b)
         rb_active <= RBSEL_RST;
      else if (soft_go)
         rb_active <= RBSEL_RST;
      else if (reg_req_i.wr && hit_rbsel)
         rb_active <= wdata_ord[RBSEL_BIT];
   end

   // mode seen by the framer and the rest of the device
   assign port_mode_o = '{out_pin_dir: dir_eff, lsb_first: lsb_eff,
                          step_up: lsb_eff, rb_active: rb_active};

   logic [BANK_DEPTH*8-1:0] buf_all; // buffer copy, whole bank
   logic [7:0] buf_rd; // buffer read data, one edge after the request
   logic [7:0] act_rd; // active read data, one edge after the request
   logic upd_go; // buffer to active transfer on this edge

   // serial writes land only in the buffer copy
   byte_bank #(.DEPTH(BANK_DEPTH), .AW(BANK_AW), .RST_VAL(BANK_RST)) u_buf (
      .clk_i(link_clk_i), .rst_b_i(link_rst_b), .clear_i(soft_go),
      .wr_i(reg_req_i.wr && in_bank && !soft_go),
      .wr_addr_i(bank_ofs[BANK_AW-1:0]), .wr_data_i(wdata_ord), .load_i(1'b0),
      .load_data_i('0), .rd_addr_i(bank_ofs[BANK_AW-1:0]), .rd_data_o(buf_rd),
      .all_o(buf_all));
   // active copy changes only by a whole-bank transfer or a reset
   byte_bank #(.DEPTH(BANK_DEPTH), .AW(BANK_AW), .RST_VAL(BANK_RST)) u_act (
      .clk_i(link_clk_i), .rst_b_i(link_rst_b), .clear_i(soft_go),
      .wr_i(1'b0), .wr_addr_i(bank_ofs[BANK_AW-1:0]), .wr_data_i(wdata_ord),
      .load_i(upd_go),
      .load_data_i(buf_all), .rd_addr_i(bank_ofs[BANK_AW-1:0]), .rd_data_o(act_rd),
      .all_o(active_regs_o));

   logic rd_q; // a read was taken on the previous edge
   logic bank_q; // that read addressed the bank
   logic [7:0] reg_q; // snapshot of a plain register or the unmapped value
   logic [7:0] sel_data; // chosen read byte in register bit order
   logic [7:0] shift; // outgoing read byte, first bit in bit 7

   // first read edge: classify and snapshot plain registers
   always_ff @(posedge link_clk_i or negedge link_rst_b)
   begin
      if (!link_rst_b)
      begin
         rd_q <= 1'b0;
         bank_q <= 1'b0;
         reg_q <= UNMAPPED_VAL;
      end
      else
      begin
         rd_q <= reg_req_i.rd;
         bank_q <= in_bank;
         if (hit_cfg)
            reg_q <= cfg;
         else if (hit_rbsel)
            reg_q <= {7'h00, rb_active}; // upper bits read as zero
         else
            reg_q <= UNMAPPED_VAL;
      end
   end

   // bank readback follows the select bit
   assign sel_data = !bank_q ? reg_q :
                     rb_active ? act_rd :
                     buf_rd;

   // answer to the framer, one process so the struct has a single driver;
   // read data on the second read edge, next address on the request edge
   always_ff @(posedge link_clk_i or negedge link_rst_b)
   begin
      if (!link_rst_b)
      begin
         reg_rsp_o.valid <= 1'b0;
         reg_rsp_o.rdata <= UNMAPPED_VAL;
         reg_rsp_o.next_addr <= '0;
      end
      else
      begin
         reg_rsp_o.valid <= rd_q;
         if (rd_q)
            reg_rsp_o.rdata <= order_byte(sel_data, lsb_eff);
         if ((reg_req_i.rd || reg_req_i.wr) && lsb_eff)
            reg_rsp_o.next_addr <= reg_req_i.addr + 12'h001;
         else if (reg_req_i.rd || reg_req_i.wr)
            reg_rsp_o.next_addr <= reg_req_i.addr - 12'h001;
      end
   end

   // shifter: load on the answer edge, shift once per driven bit
   always_ff @(posedge link_clk_i or negedge link_rst_b)
   begin
      if (!link_rst_b)
         shift <= 8'h00;
      else if (rd_q)
         shift <= order_byte(sel_data, lsb_eff);
      else if (read_drive_i)
         shift <= {shift[6:0], 1'b0};
   end

   // pin values come straight from the shifter flop
   assign data_pin_o = shift[7];
   assign serial_output_pin_o = shift[7];
   // only one pin drives read data; the other stays released
   assign data_pin_oe_o = read_drive_i & ~dir_eff;
   assign serial_output_pin_oe_o = read_drive_i & dir_eff;

   logic upd_tgl; // core request toggle
   logic upd_tgl_s; // request toggle seen in the link domain
   logic upd_seen; // last request toggle handled by the link
   logic ack_s; // handled toggle seen back in the core
   logic srst_tgl; // flips each time a soft reset executes
   logic srst_s; // that toggle in the core domain
   logic srst_seen; // last soft reset toggle handled by the core
   update_state_t upd_state; // core handshake state

   // toggles cross as single levels, so one flop of skew is harmless
   bit_sync #(.W(1), .RST_VAL(1'b0)) u_upd_sync (.clk_i(link_clk_i), .rst_b_i(link_rst_b),
      .d_i(upd_tgl), .q_o(upd_tgl_s));
   bit_sync #(.W(1), .RST_VAL(1'b0)) u_ack_sync (.clk_i(core_clk_i), .rst_b_i(core_rst_b),
      .d_i(upd_seen), .q_o(ack_s));
   bit_sync #(.W(1), .RST_VAL(1'b0)) u_srst_sync (.clk_i(core_clk_i), .rst_b_i(core_rst_b),
      .d_i(srst_tgl), .q_o(srst_s));
   // mode bits are independent levels; a change may land a cycle apart per bit
   bit_sync #(.W(4), .RST_VAL(1'b0)) u_mode_sync (.clk_i(core_clk_i), .rst_b_i(core_rst_b),
      .d_i(port_mode_o), .q_o(core_mode_o));

   // link side: a toggle edge copies buffer to active and acknowledges
   assign upd_go = upd_tgl_s ^ upd_seen;
   always_ff @(posedge link_clk_i or negedge link_rst_b)
   begin
      if (!link_rst_b)
         upd_seen <= 1'b0;
      else
         upd_seen <= upd_tgl_s;
   end

   // link side: report each executed soft reset
   always_ff @(posedge link_clk_i or negedge link_rst_b)
   begin
      if (!link_rst_b)
         srst_tgl <= 1'b0;
      else if (soft_go)
         srst_tgl <= ~srst_tgl;
   end

   // core side: one transfer in flight; requests while busy are dropped
   always_ff @(posedge core_clk_i or negedge core_rst_b)
   begin
      if (!core_rst_b)
      begin
         upd_state <= UPD_IDLE;
         upd_tgl <= 1'b0;
      end
      else
      begin
         case (upd_state)
            UPD_IDLE:
            begin
               if (update_i)
               begin
                  upd_tgl <= ~upd_tgl;
                  upd_state <= UPD_BUSY;
               end
            end
            UPD_BUSY:
            begin
               if (ack_s == upd_tgl)
                  upd_state <= UPD_IDLE;
            end
            default:
               upd_state <= UPD_IDLE;
         endcase
      end
   end
   assign update_busy_o = (upd_state == UPD_BUSY);

   // core side: one-cycle pulse per soft reset
   always_ff @(posedge core_clk_i or negedge core_rst_b)
   begin
      if (!core_rst_b)
      begin
         srst_seen <= 1'b0;
         soft_reset_seen_o <= 1'b0;
      end
      else
      begin
         srst_seen <= srst_s;
         soft_reset_seen_o <= srst_s ^ srst_seen;
      end
   end

   out_pin_idle_a: assert property (
      @(posedge link_clk_i) disable iff (!link_rst_b)
      !cfg[DIR_BIT] |-> !serial_output_pin_oe_o)
      else $error("output pin driven in bidirectional mode");

   out_pin_read_a: assert property (
      @(posedge link_clk_i) disable iff (!link_rst_b)
      (dir_eff && read_drive_i) |-> (serial_output_pin_oe_o && !data_pin_oe_o))
      else $error("unidirectional read not on output pin");

   addr_step_down_a: assert property (
      @(posedge link_clk_i) disable iff (!link_rst_b)
      (reg_req_i.rd && !lsb_eff) |=>
      reg_rsp_o.next_addr == $past(reg_req_i.addr) - 12'h001)
      else $error("address did not step down");

   addr_step_up_a: assert property (
      @(posedge link_clk_i) disable iff (!link_rst_b)
      (reg_req_i.wr && lsb_eff) |=>
      reg_rsp_o.next_addr == $past(reg_req_i.addr) + 12'h001)
      else $error("address did not step up");

   i2c_ignore_a: assert property (
      @(posedge link_clk_i) disable iff (!link_rst_b)
      i2c_q |-> (!port_mode_o.lsb_first && !port_mode_o.out_pin_dir))
      else $error("order or direction active in i2c mode");

   soft_defaults_a: assert property (
      @(posedge link_clk_i) disable iff (!link_rst_b)
      soft_go |=> (rb_active == RBSEL_RST && active_regs_o == {BANK_DEPTH{BANK_RST}} &&
                   cfg == ($past(reg_req_i.wr && hit_cfg) ? $past(wdata_ord) : CFG_RST)))
      else $error("soft reset left a register changed");

   spi_self_clear_a: assert property (
      @(posedge link_clk_i) disable iff (!link_rst_b)
      (!i2c_q && !soft_go && reg_req_i.wr && hit_cfg && wdata_ord[SRST_BIT])
      |=> soft_go ##1 !cfg[SRST_BIT])
      else $error("soft reset bit did not clear after one spi clock");

   i2c_self_clear_a: assert property (
      @(posedge link_clk_i) disable iff (!link_rst_b)
      (i2c_q && !soft_go && reg_req_i.wr && hit_cfg && reg_req_i.wdata[SRST_BIT])
      |=> cfg[SRST_BIT] ##1 (cfg == CFG_RST))
      else $error("soft reset bit did not clear after one scl cycle");

   buf_readback_a: assert property (
      @(posedge link_clk_i) disable iff (!link_rst_b)
      (rd_q && bank_q && !rb_active) |=>
      reg_rsp_o.rdata == order_byte($past(buf_rd), $past(lsb_eff)))
      else $error("buffer readback returned wrong copy");

   act_readback_a: assert property (
      @(posedge link_clk_i) disable iff (!link_rst_b)
      (rd_q && bank_q && rb_active) |=>
      reg_rsp_o.rdata == order_byte($past(act_rd), $past(lsb_eff)))
      else $error("active readback returned wrong copy");

   active_kept_a: assert property (
      @(posedge link_clk_i) disable iff (!link_rst_b)
      (!upd_go && !soft_go) |=> $stable(active_regs_o))
      else $error("active copy changed without a transfer");
endmodule
`default_nettype wire

// ### verification/host_framer_model.sv
// host side framer model: link clock, register requests and pin sampling
`timescale 1ns/1ps
`default_nettype none
module host_framer_model (
   output logic link_clk_o,
   output serial_cfg_pkg::reg_req_t reg_req_o,
   output logic read_drive_o,
   input wire serial_cfg_pkg::reg_rsp_t reg_rsp_i,
   input wire logic data_pin_i,
   input wire logic data_pin_oe_i,
   input wire logic out_pin_i,
   input wire logic out_pin_oe_i
);
   import serial_cfg_pkg::*;
   // the serial clock stands low between frames
   initial
   begin
      link_clk_o = 1'b0;
      reg_req_o = '0;
      read_drive_o = 1'b0;
   end
   // one link period; requests only change while the clock is low
   task automatic tick();
      #62.5 link_clk_o = 1'b1;
      #62.5 link_clk_o = 1'b0;
   endtask
   // write one byte; idle fields are inverted so stale values never match
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      reg_req_o = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
      tick();
      reg_req_o = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
      tick();
   endtask
   // read one byte; the answer stands from the second edge, for one cycle
   task automatic rd(input logic [ADDR_W-1:0] a, output logic [DATA_W-1:0] d,
                     output logic v);
      reg_req_o = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: ~reg_req_o.wdata};
      tick();
      reg_req_o.rd = 1'b0;
      reg_req_o.addr = ~a;
      tick();
      v = reg_rsp_i.valid;
      d = reg_rsp_i.rdata;
   endtask
   // shift the loaded byte out, first bit first
   task automatic shift_out(input logic sel, output logic [7:0] bits, output logic [1:0] oe);
      read_drive_o = 1'b1;
      #1 oe = {data_pin_oe_i, out_pin_oe_i};
      for (int i = 7; i >= 0; i--)
      begin
         // an undriven line reads as zero, so a missing enable shows up
         bits[i] = sel ? (out_pin_i & out_pin_oe_i) : (data_pin_i & data_pin_oe_i);
         if (i > 0)
            tick();
      end
      read_drive_o = 1'b0;
   endtask
endmodule
`default_nettype wire

// ### verification/serial_port_config_regs_bench.sv
// self-checking bench for the serial port configuration registers
`timescale 1ns/1ps
`default_nettype none
module serial_port_config_regs_bench;
   import serial_cfg_pkg::*;
   logic core_clk = 1'b0; // 10 MHz core clock
   logic rst_b = 1'b0; // held low at start
   logic i2c_mode = 1'b0;
   logic update = 1'b0;
   wire logic link_clk;
   reg_req_t req;
   reg_rsp_t rsp;
   logic read_drive;
   logic dpin, dpin_oe, opin, opin_oe, busy, srst_seen;
   port_mode_t mode, core_mode;
   logic [127:0] active; // active bank, entry 0 in the low byte
   int error_cnt = 0;
   int total_checks = 0;
   logic [7:0] d;
   logic v;
   logic [1:0] oe2; // {data pin enable, output pin enable}
   // core clock
   initial
   begin
      forever #50 core_clk = ~core_clk;
   end
   serial_port_config_regs dut (.core_clk_i(core_clk), .rst_b_i(rst_b),
      .link_clk_i(link_clk), .i2c_mode_i(i2c_mode), .reg_req_i(req), .reg_rsp_o(rsp),
      .read_drive_i(read_drive), .data_pin_o(dpin), .data_pin_oe_o(dpin_oe),
      .serial_output_pin_o(opin), .serial_output_pin_oe_o(opin_oe), .port_mode_o(mode),
      .active_regs_o(active), .update_i(update), .update_busy_o(busy),
      .soft_reset_seen_o(srst_seen), .core_mode_o(core_mode));
   host_framer_model host (.link_clk_o(link_clk), .reg_req_o(req), .read_drive_o(read_drive),
      .reg_rsp_i(rsp), .data_pin_i(dpin), .data_pin_oe_i(dpin_oe), .out_pin_i(opin),
      .out_pin_oe_i(opin_oe));
   // compare and count
   task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
      total_checks++;
      if (seen !== exp)
      begin
         error_cnt++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask
   // verdict and end of run
   task automatic stop_test();
      if (error_cnt == 0 && total_checks > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // read one register and compare the answer
   task automatic rd_chk(input logic [11:0] a, input logic [7:0] exp);
      host.rd(a, d, v);
      check("rsp_valid", v, 1'b1);
      check("rdata", d, exp);
   endtask
   // wait, bounded, for the core side soft reset pulse
   task automatic wait_srst();
      int n;
      n = 0;
      while (srst_seen !== 1'b1 && n < 20)
      begin
         @(posedge core_clk);
         #1 n++;
      end
      check("srst_seen", srst_seen, 1'b1);
      if (n == 20)
         stop_test();
   endtask
   // copy buffer to active; the link clock must run for the copy to land
   task automatic do_update();
      int n;
      n = 0;
      @(posedge core_clk);
      update <= 1'b1;
      @(posedge core_clk);
      update <= 1'b0;
      @(posedge core_clk);
      #1 check("busy", busy, 1'b1);
      while (busy !== 1'b0 && n < 40)
      begin
         host.tick();
         n++;
      end
      check("busy_done", busy, 1'b0);
      if (n == 40)
         stop_test();
   endtask
   // main sequence
   initial
   begin
      repeat (3) host.tick();
      @(posedge core_clk);
      rst_b <= 1'b1;
      repeat (3) host.tick();
      check("mode", mode, 4'h0);
      rd_chk(CFG_OFS, CFG_RST);
      rd_chk(RBSEL_OFS, 8'h00);
      host.wr(12'h010, 8'ha5);
      check("next_addr", rsp.next_addr, 12'h00f);
      rd_chk(12'h010, 8'ha5);
      host.shift_out(1'b0, d, oe2);
      check("dpin_bits", d, 8'ha5);
      check("pin_oe", oe2, 2'b10);
      host.wr(RBSEL_OFS, 8'h01);
      rd_chk(12'h010, BANK_RST);
      do_update();
      check("active", active[7:0], 8'ha5);
      // unidirectional mode with the mirror nibble filled in
      host.wr(CFG_OFS, 8'h81);
      rd_chk(12'h010, 8'ha5);
      host.shift_out(1'b1, d, oe2);
      check("opin_bits", d, 8'ha5);
      check("pin_oe", oe2, 2'b01);
      check("core_mode", core_mode, 4'b1001);
      // lsb first: address steps up and bytes arrive reversed
      host.wr(CFG_OFS, 8'h42);
      check("mode", mode, 4'b0111);
      host.wr(12'h010, 8'h01);
      check("next_addr", rsp.next_addr, 12'h011);
      do_update();
      check("active", active[7:0], 8'h80);
      rd_chk(12'h010, 8'h01);
      // i2c mode overrides order and direction
      @(posedge core_clk);
      i2c_mode <= 1'b1;
      repeat (3) host.tick();
      check("mode", mode, 4'b0001);
      host.wr(12'h010, 8'h01);
      check("next_addr", rsp.next_addr, 12'h00f);
      // soft reset, first in i2c mode then in spi mode
      for (int m = 1; m >= 0; m--)
      begin
         @(posedge core_clk);
         i2c_mode <= m[0];
         repeat (3) host.tick();
         host.wr(12'h010, 8'h5a);
         host.wr(CFG_OFS, 8'h24);
         wait_srst();
         rd_chk(CFG_OFS, CFG_RST);
         rd_chk(RBSEL_OFS, 8'h00);
         rd_chk(12'h010, BANK_RST);
      end
      stop_test();
   end
endmodule
`default_nettype wire
